/* File: rtl/pnp_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module pnp_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             push;
  logic             pop;

  // Full when pointers match except the wrap bit.
  assign inReady  = (wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0]) || (wrPtr_q[AW] == rdPtr_q[AW]);
  assign outValid = wrPtr_q != rdPtr_q;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_q[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  a_fifo_no_overrun : assert property (@(posedge clk) disable iff (!resetn)
    !inReady |=> $stable(wrPtr_q))
    else $error("fifo pointer moved while full");

endmodule : pnp_fifo
`default_nettype wire

/* File: rtl/pnp_pkg.sv */
package pnp_pkg;

  // Command bytes taken on a command load.
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEP   = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEP   = 8'h03;

  // Action-select codes, high pin first.
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // Byte-select pairs, second select then first select.
  localparam logic [1:0] SEL_LOW  = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_EXT  = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;

  // Unprogrammed fuse and lock state; a 0 marks a programmed bit.
  localparam logic [7:0] FUSE_ERASED = 8'hFF;
  localparam logic [1:0] LOCK_ERASED = 2'h3;
  localparam logic [1:0] LOCK_ALL_SET = 2'h0;
  localparam logic [5:0] LOCK_PAD    = 6'h3F;
  localparam logic [7:0] BYTE_BLANK  = 8'hFF;
  localparam logic [7:0] SIG_LAST    = 8'h02;
  localparam logic [7:0] CAL_ADDR    = 8'h00;

  // Page geometry: flash page words and EEPROM page bytes, as address bits.
  localparam int PAGE_BITS = 5;
  localparam int EE_BITS   = 2;

  // Self-timed programming time and the cycle count at the clock rate.
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS  = 4500000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Depth of the write-out FIFO.
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STREAM = 2'b01,
    ST_WAIT   = 2'b11
  } pnp_state_t;

endpackage : pnp_pkg

/* File: rtl/pnp_port.sv */
`timescale 1ns/1ns
`default_nettype none
module pnp_port #(
  parameter int         BUSY_CYCLES = pnp_pkg::PROG_CYCLES,
  parameter logic [7:0] SIG_BYTE0   = 8'hA5,
  parameter logic [7:0] SIG_BYTE1   = 8'h5A,
  parameter logic [7:0] SIG_BYTE2   = 8'h3C,
  parameter logic [7:0] CAL_BYTE    = 8'h80
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        action_select_hi,
  input  wire logic        action_select_lo,
  input  wire logic        byte_select_first,
  input  wire logic        byte_select_second,
  input  wire logic        page_latch_strobe,
  input  wire logic        strobe_clock_in,
  input  wire logic        writeStrobeN,
  input  wire logic        outputEnableN,
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output logic             dataOeN,
  output logic             ready_busy_flag,
  output logic      [15:0] rdAddr,
  input  wire logic [15:0] flashRdData,
  input  wire logic [7:0]  eepRdData,
  output logic             nvmWrValid,
  input  wire logic        nvmWrReady,
  output logic             nvmWrIsEeprom,
  output logic      [15:0] nvmWrAddr,
  output logic      [15:0] nvmWrData,
  output logic      [7:0]  lowFuse,
  output logic      [7:0]  highFuse,
  output logic      [7:0]  extFuse,
  output logic      [1:0]  lockBits
);
  import pnp_pkg::*;

  localparam int PAGE_WORDS = 1 << PAGE_BITS;
  localparam int CW         = $clog2(BUSY_CYCLES + 1);
  localparam logic [CW-1:0] BUSY_LOAD = CW'(BUSY_CYCLES);
  localparam int FW = 1 + 16 + 16;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe edges and unregistered selects.
  logic clkInPrev_q;
  logic pageLatchPrev_q;
  logic writePrev_q;
  logic clkRise;
  logic latchRise;
  logic writeFall;
  logic [1:0] action;
  logic [1:0] selPair;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clkInPrev_q     <= 1'b0;
      pageLatchPrev_q <= 1'b0;
      writePrev_q     <= 1'b1;
    end else begin
      clkInPrev_q     <= strobe_clock_in;
      pageLatchPrev_q <= page_latch_strobe;
      writePrev_q     <= writeStrobeN;
    end
  end

  assign clkRise   = strobe_clock_in && !clkInPrev_q;
  assign latchRise = page_latch_strobe && !pageLatchPrev_q;
  assign writeFall = !writeStrobeN && writePrev_q;
  assign action    = {action_select_hi, action_select_lo};
  assign selPair   = {byte_select_second, byte_select_first};

  ////////////////////////////////////////////////////////////////////////////
  // Command, address and data loads; held until reloaded.
  logic [7:0] cmd_q;
  logic [7:0] addrLo_q;
  logic [7:0] addrHi_q;
  logic [7:0] dataLo_q;
  logic [7:0] dataHi_q;
  logic       loadCmd;

  assign loadCmd = clkRise && action == ACT_CMD;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q    <= CMD_NOP;
      addrLo_q <= '0;
      addrHi_q <= '0;
      dataLo_q <= '0;
      dataHi_q <= '0;
    end else if (clkRise) begin
      unique case (action)
        ACT_CMD: begin
          cmd_q <= dataIn;
        end
        ACT_ADDR: begin
          if (byte_select_first) begin
            addrHi_q <= dataIn;
          end else begin
            addrLo_q <= dataIn;
          end
        end
        ACT_DATA: begin
          if (byte_select_first) begin
            dataHi_q <= dataIn;
          end else begin
            dataLo_q <= dataIn;
          end
        end
        ACT_IDLE: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer, one entry per word, indexed by the low address bits.
  logic [15:0]           pageBuf_q [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] pageValid_q;
  logic [PAGE_BITS-1:0]  latchIdx;
  logic [PAGE_BITS-1:0]  idx_q;
  pnp_state_t            state_q;
  logic                  streamDone;

  // An EEPROM page is only a few bytes wide, so fewer address bits pick the entry.
  assign latchIdx = (cmd_q == CMD_WR_EEP) ? PAGE_BITS'(addrLo_q[EE_BITS-1:0])
                                          : addrLo_q[PAGE_BITS-1:0];

  always_ff @(posedge clk) begin
    if (latchRise) begin
      pageBuf_q[latchIdx] <= {dataHi_q, dataLo_q};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pageValid_q <= '0;
    end else begin
      if ((loadCmd && dataIn == CMD_NOP) || streamDone) begin
        pageValid_q <= '0;
      end
      // A latch in the same cycle as a clear still marks its entry.
      if (latchRise) begin
        pageValid_q[latchIdx] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed programming sequence.
  logic          isEep_q;
  logic [CW-1:0] busyCnt_q;
  logic          startPage;
  logic          startBits;
  logic          fifoInReady;
  logic          fifoEmpty;
  logic          advance;
  logic [PAGE_BITS-1:0] lastIdx;

  assign startPage = writeFall && state_q == ST_IDLE
                     && (cmd_q == CMD_WR_FLASH
                     || (cmd_q == CMD_WR_EEP && !byte_select_first));
  assign startBits = writeFall && state_q == ST_IDLE
                     && (cmd_q == CMD_WR_FUSE || cmd_q == CMD_WR_LOCK);
  assign lastIdx   = isEep_q ? PAGE_BITS'((1 << EE_BITS) - 1) : PAGE_BITS'(PAGE_WORDS - 1);
  assign advance   = state_q == ST_STREAM && (!pageValid_q[idx_q] || fifoInReady);
  assign streamDone = advance && idx_q == lastIdx;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= ST_IDLE;
      idx_q     <= '0;
      isEep_q   <= 1'b0;
      busyCnt_q <= '0;
    end else begin
      if (busyCnt_q != '0) begin
        busyCnt_q <= busyCnt_q - 1'b1;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (startPage) begin
            state_q   <= ST_STREAM;
            idx_q     <= '0;
            isEep_q   <= cmd_q == CMD_WR_EEP;
            busyCnt_q <= BUSY_LOAD;
          end else if (startBits) begin
            state_q   <= ST_WAIT;
            busyCnt_q <= BUSY_LOAD;
          end
        end
        ST_STREAM: begin
          if (streamDone) begin
            state_q <= ST_WAIT;
          end else if (advance) begin
            idx_q <= idx_q + 1'b1;
          end
        end
        ST_WAIT: begin
          if (busyCnt_q <= CW'(1) && fifoEmpty) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign ready_busy_flag = state_q == ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Fuse and lock bits.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowFuse  <= FUSE_ERASED;
      highFuse <= FUSE_ERASED;
      extFuse  <= FUSE_ERASED;
      lockBits <= LOCK_ERASED;
    end else if (startBits) begin
      if (cmd_q == CMD_WR_FUSE) begin
        unique case (selPair)
          SEL_LOW:  lowFuse  <= dataLo_q;
          SEL_LOCK: highFuse <= dataLo_q;
          SEL_EXT:  extFuse  <= dataLo_q;
          SEL_HIGH: begin
          end
        endcase
      end else if (lockBits != LOCK_ALL_SET) begin
        lockBits <= lockBits & dataLo_q[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back onto the data bus.
  logic [7:0] rdByte;

  assign rdAddr = {addrHi_q, addrLo_q};

  always_comb begin
    rdByte = BYTE_BLANK;
    unique case (cmd_q)
      CMD_RD_FLASH: rdByte = byte_select_first ? flashRdData[15:8]
                                               : flashRdData[7:0];
      CMD_RD_EEP:   rdByte = byte_select_first ? BYTE_BLANK : eepRdData;
      CMD_RD_FUSE: begin
        unique case (selPair)
          SEL_LOW:  rdByte = lowFuse;
          SEL_HIGH: rdByte = highFuse;
          SEL_EXT:  rdByte = extFuse;
          SEL_LOCK: rdByte = {LOCK_PAD, lockBits};
        endcase
      end
      CMD_RD_SIG: begin
        if (byte_select_first) begin
          rdByte = addrLo_q == CAL_ADDR ? CAL_BYTE : BYTE_BLANK;
        end else if (addrLo_q <= SIG_LAST) begin
          rdByte = addrLo_q == 8'h00 ? SIG_BYTE0 :
                   addrLo_q == 8'h01 ? SIG_BYTE1 : SIG_BYTE2;
        end
      end
      default: rdByte = BYTE_BLANK;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataOut <= '0;
      dataOeN <= 1'b1;
    end else begin
      dataOut <= rdByte;
      dataOeN <= outputEnableN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page words leave through the FIFO to the array writer.
  logic [FW-1:0] fifoIn;
  logic [15:0]   wordAddr;
  logic          fifoOutValid;

  assign wordAddr = isEep_q ? {rdAddr[15:EE_BITS], idx_q[EE_BITS-1:0]}
                            : {rdAddr[15:PAGE_BITS], idx_q};
  assign fifoIn     = {isEep_q, wordAddr, pageBuf_q[idx_q]};
  assign nvmWrValid = fifoOutValid;
  assign fifoEmpty  = !fifoOutValid;

  pnp_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .resetn  (resetn),
    .inValid (state_q == ST_STREAM && pageValid_q[idx_q]),
    .inReady (fifoInReady),
    .inData  (fifoIn),
    .outValid(fifoOutValid),
    .outReady(nvmWrReady),
    .outData ({nvmWrIsEeprom, nvmWrAddr, nvmWrData})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_cmd_load : assert property (@(posedge clk) disable iff (!resetn)
    loadCmd |=> cmd_q == $past(dataIn)) else $error("command not loaded");
  a_addr_low : assert property (@(posedge clk) disable iff (!resetn)
    clkRise && action == ACT_ADDR && !byte_select_first |=> addrLo_q == $past(dataIn))
    else $error("low address not loaded");
  a_data_high : assert property (@(posedge clk) disable iff (!resetn)
    clkRise && action == ACT_DATA && byte_select_first |=> dataHi_q == $past(dataIn))
    else $error("high data not loaded");
  a_idle_action : assert property (@(posedge clk) disable iff (!resetn)
    clkRise && action == ACT_IDLE |=> $stable(cmd_q) && $stable(addrLo_q) && $stable(dataLo_q))
    else $error("idle action changed state");
  a_nop_clears : assert property (@(posedge clk) disable iff (!resetn)
    loadCmd && dataIn == CMD_NOP |=> pageValid_q == '0)
    else $error("no-op left page entries");
  a_busy_start : assert property (@(posedge clk) disable iff (!resetn)
    startPage |=> !ready_busy_flag [*2]) else $error("busy not raised");
  a_fuse_write : assert property (@(posedge clk) disable iff (!resetn)
    startBits && cmd_q == CMD_WR_FUSE && selPair == SEL_LOW |=> lowFuse == $past(dataLo_q))
    else $error("low fuse not written");
  a_lock_refuse : assert property (@(posedge clk) disable iff (!resetn)
    lockBits == LOCK_ALL_SET |=> lockBits == LOCK_ALL_SET)
    else $error("locked bits changed");
  a_lock_sticky : assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (lockBits & ~$past(lockBits)) == '0)
    else $error("lock bit cleared");
  a_bus_release : assert property (@(posedge clk) disable iff (!resetn)
    outputEnableN |=> dataOeN) else $error("bus driven with output-enable high");
  a_flash_read : assert property (@(posedge clk) disable iff (!resetn)
    cmd_q == CMD_RD_FLASH && !byte_select_first && !outputEnableN
    |=> dataOut == $past(flashRdData[7:0]) && !dataOeN)
    else $error("flash low byte not driven");

  c_flash_page : cover property (@(posedge clk) disable iff (!resetn)
    startPage && cmd_q == CMD_WR_FLASH);
  c_eep_page : cover property (@(posedge clk) disable iff (!resetn)
    startPage && cmd_q == CMD_WR_EEP);
  c_fifo_stall : cover property (@(posedge clk) disable iff (!resetn)
    state_q == ST_STREAM && !fifoInReady);
  c_lock_refused : cover property (@(posedge clk) disable iff (!resetn)
    startBits && cmd_q == CMD_WR_LOCK && lockBits == LOCK_ALL_SET);

endmodule : pnp_port
`default_nettype wire

/* File: tb/pnp_nvm_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pnp_nvm_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        stall,
  input  wire logic [15:0] rdAddr,
  output logic      [15:0] flashRdData,
  output logic      [7:0]  eepRdData,
  input  wire logic        nvmWrValid,
  output logic             nvmWrReady,
  input  wire logic        nvmWrIsEeprom,
  input  wire logic [15:0] nvmWrAddr,
  input  wire logic [15:0] nvmWrData,
  output logic      [7:0]  wrCount
);
  logic [15:0] flashMem [0:1023];
  logic [7:0]  eepMem   [0:63];

  ////////////////////////////////////////////////////////////////////////////////
  // Erased cells read as all ones until a word is written.
  initial begin
    for (int i = 0; i < 1024; i++) flashMem[i] = 16'hFFFF;
    for (int i = 0; i < 64; i++) eepMem[i] = 8'hFF;
  end

  assign flashRdData = flashMem[rdAddr[9:0]];
  assign eepRdData   = eepMem[rdAddr[5:0]];
  assign nvmWrReady  = !stall;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrCount <= 8'h00;
    end else if (nvmWrValid && nvmWrReady) begin
      wrCount <= wrCount + 8'h01;
      if (nvmWrIsEeprom) begin
        eepMem[nvmWrAddr[5:0]] <= nvmWrData[7:0];
      end else begin
        flashMem[nvmWrAddr[9:0]] <= nvmWrData;
      end
    end
  end
endmodule : pnp_nvm_model
`default_nettype wire

/* File: tb/test_parallel_nvm_programming_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_parallel_nvm_programming_port;
  import pnp_pkg::*;
  // Identification values are arbitrary.
  localparam logic [7:0] SIG0 = 8'h61;
  localparam logic [7:0] SIG1 = 8'h62;
  localparam logic [7:0] SIG2 = 8'h63;
  localparam logic [7:0] CAL  = 8'h4E;

  logic clk, resetn, actHi, actLo, bsFirst, bsSecond, pageLatch, clockIn, wrN, oeN, stall;
  logic [7:0]  tbData, busWire, dataOut, eepRd, lowFuse, highFuse, extFuse, wrCount;
  logic [15:0] rdAddr, flashRd, nvmWrAddr, nvmWrData;
  logic [1:0]  lockBits;
  logic        dataOeN, readyBusy, nvmWrValid, nvmWrReady, nvmWrIsEeprom;
  logic [7:0]  lockIn  [4] = '{8'hFE, 8'hFF, 8'hFD, 8'hFF};
  logic [1:0]  lockExp [4] = '{2'h2, 2'h2, 2'h0, 2'h0};
  logic [7:0]  sigExp  [3] = '{SIG0, SIG1, SIG2};
  int          errors, nChecks;

  assign busWire = !dataOeN ? dataOut : tbData;

  pnp_port #(.BUSY_CYCLES(8), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
    .CAL_BYTE(CAL)) DUT (
    .clk(clk), .resetn(resetn), .action_select_hi(actHi), .action_select_lo(actLo),
    .byte_select_first(bsFirst), .byte_select_second(bsSecond),
    .page_latch_strobe(pageLatch), .strobe_clock_in(clockIn), .writeStrobeN(wrN),
    .outputEnableN(oeN), .dataIn(busWire), .dataOut(dataOut), .dataOeN(dataOeN),
    .ready_busy_flag(readyBusy), .rdAddr(rdAddr), .flashRdData(flashRd),
    .eepRdData(eepRd), .nvmWrValid(nvmWrValid), .nvmWrReady(nvmWrReady),
    .nvmWrIsEeprom(nvmWrIsEeprom), .nvmWrAddr(nvmWrAddr), .nvmWrData(nvmWrData),
    .lowFuse(lowFuse), .highFuse(highFuse), .extFuse(extFuse), .lockBits(lockBits));

  pnp_nvm_model arrayModel (
    .clk(clk), .resetn(resetn), .stall(stall), .rdAddr(rdAddr), .flashRdData(flashRd),
    .eepRdData(eepRd), .nvmWrValid(nvmWrValid), .nvmWrReady(nvmWrReady),
    .nvmWrIsEeprom(nvmWrIsEeprom), .nvmWrAddr(nvmWrAddr), .nvmWrData(nvmWrData),
    .wrCount(wrCount));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Strobes stay high and low two cycles each, selects change with the rising strobe.
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
    @(posedge clk);
    #2;
    {actHi, actLo} = act;
    bsFirst = bs1;
    bsSecond = 1'b0;
    tbData = val;
    clockIn = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    clockIn = 1'b0;
    repeat (2) @(posedge clk);
  endtask : load

  task automatic latch();
    @(posedge clk);
    #2;
    pageLatch = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    pageLatch = 1'b0;
    repeat (2) @(posedge clk);
  endtask : latch

  task automatic wr(input logic bs2, input logic bs1);
    @(posedge clk);
    #2;
    bsSecond = bs2;
    bsFirst = bs1;
    wrN = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    wrN = 1'b1;
  endtask : wr

  task automatic waitReady();
    int n;
    n = 0;
    while (readyBusy !== 1'b1 && n < 400) begin
      @(posedge clk);
      #2;
      n++;
    end
    check("ready after write", {15'h0000, readyBusy}, 16'h0001);
  endtask : waitReady

  task automatic rd(input string what, input logic bs2, input logic bs1, input logic [7:0] exp);
    @(posedge clk);
    #2;
    bsSecond = bs2;
    bsFirst = bs1;
    oeN = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    check("bus driven", {15'h0000, dataOeN}, 16'h0000);
    check(what, {8'h00, dataOut}, {8'h00, exp});
    oeN = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    check("bus released", {15'h0000, dataOeN}, 16'h0001);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    {resetn, actHi, actLo, bsFirst, bsSecond, pageLatch, clockIn, oeN, wrN} = 9'h0C3;
    tbData = 8'h00;
    stall = 1'b0;
    errors = 0;
    nChecks = 0;
    repeat (10) @(posedge clk);
    #2;
    resetn = 1'b1;
    check("ready at reset", {15'h0000, readyBusy}, 16'h0001);
    check("bus at reset", {15'h0000, dataOeN}, 16'h0001);
    check("fuses at reset", {lowFuse, extFuse}, {FUSE_ERASED, FUSE_ERASED});
    check("lock at reset", {14'h0000, lockBits}, {14'h0000, LOCK_ERASED});
    $display("test reset done");
    // A full FIFO with the array stalled must hold the page until the stall ends.
    stall = 1'b1;
    load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    load(ACT_ADDR, 1'b1, 8'h01);
    for (int i = 0; i < 20; i++) begin
      load(ACT_ADDR, 1'b0, 8'hE0 + i[7:0]);
      load(ACT_DATA, 1'b0, 8'h10 + i[7:0]);
      load(ACT_DATA, 1'b1, 8'hA0 + i[7:0]);
      latch();
    end
    wr(1'b0, 1'b0);
    check("busy", {15'h0000, readyBusy}, 16'h0000);
    repeat (40) @(posedge clk);
    #2;
    check("stalled valid", {15'h0000, nvmWrValid}, 16'h0001);
    check("stalled busy", {15'h0000, readyBusy}, 16'h0000);
    stall = 1'b0;
    waitReady();
    check("words written", {8'h00, wrCount}, 16'h0014);
    load(ACT_CMD, 1'b0, CMD_NOP);
    load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    for (int i = 0; i < 21; i++) begin
      load(ACT_ADDR, 1'b0, 8'hE0 + i[7:0]);
      rd("flash low", 1'b0, 1'b0, (i < 20) ? 8'h10 + i[7:0] : BYTE_BLANK);
      rd("flash high", 1'b0, 1'b1, (i < 20) ? 8'hA0 + i[7:0] : BYTE_BLANK);
    end
    $display("test flash done");
    load(ACT_CMD, 1'b0, CMD_WR_EEP);
    load(ACT_ADDR, 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      load(ACT_ADDR, 1'b0, 8'h14 + i[7:0]);
      load(ACT_DATA, 1'b0, 8'h30 + i[7:0]);
      latch();
    end
    wr(1'b0, 1'b1);
    check("eeprom write refused", {15'h0000, readyBusy}, 16'h0001);
    wr(1'b0, 1'b0);
    check("eeprom busy", {15'h0000, readyBusy}, 16'h0000);
    waitReady();
    load(ACT_CMD, 1'b0, CMD_RD_EEP);
    for (int i = 0; i < 5; i++) begin
      load(ACT_ADDR, 1'b0, 8'h14 + i[7:0]);
      rd("eeprom byte", 1'b0, 1'b0, (i < 4) ? 8'h30 + i[7:0] : BYTE_BLANK);
    end
    $display("test eeprom done");
    load(ACT_CMD, 1'b0, CMD_WR_FUSE);
    for (int s = 0; s < 4; s++) begin
      load(ACT_DATA, 1'b0, 8'hC3 ^ s[7:0]);
      wr(s[1], s[0]);
      waitReady();
    end
    check("low fuse", {8'h00, lowFuse}, 16'h00C3);
    check("high fuse", {8'h00, highFuse}, 16'h00C2);
    check("ext fuse", {8'h00, extFuse}, 16'h00C1);
    load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd("low fuse read", 1'b0, 1'b0, 8'hC3);
    rd("high fuse read", 1'b1, 1'b1, 8'hC2);
    rd("ext fuse read", 1'b1, 1'b0, 8'hC1);
    $display("test fuse done");
    load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    for (int k = 0; k < 4; k++) begin
      load(ACT_DATA, 1'b0, lockIn[k]);
      wr(1'b0, 1'b0);
      waitReady();
      check("lock bits", {14'h0000, lockBits}, {14'h0000, lockExp[k]});
    end
    load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd("lock read", 1'b0, 1'b1, {LOCK_PAD, LOCK_ALL_SET});
    $display("test lock done");
    load(ACT_CMD, 1'b0, CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      load(ACT_ADDR, 1'b0, i[7:0]);
      rd("signature", 1'b0, 1'b0, sigExp[i]);
    end
    load(ACT_ADDR, 1'b0, CAL_ADDR);
    load(ACT_IDLE, 1'b0, 8'h55);
    rd("calibration", 1'b0, 1'b1, CAL);
    $display("test signature done");
    end_sim();
  end
endmodule : test_parallel_nvm_programming_port
`default_nettype wire
